// [fres_regs.svh]
// Register offsets, field positions, reset values and timing counts
// Assumes byte addresses on a 32-bit APB, one aligned word per register
`ifndef FRES_REGS_SVH
`define FRES_REGS_SVH

`define FRES_ADDR_W 8
`define FRES_OFF_CTRL 8'h00
`define FRES_OFF_UNLOCK 8'h04
`define FRES_OFF_ADDR_LO 8'h08
`define FRES_OFF_ADDR_HI 8'h0c
`define FRES_OFF_DATA_LO 8'h10
`define FRES_OFF_DATA_HI 8'h14

`define FRES_BIT_RD 0
`define FRES_BIT_WR 1
`define FRES_BIT_WRITE_EN 2
`define FRES_BIT_WRITE_ERR 3
`define FRES_BIT_FREE 4
`define FRES_BIT_LOAD_ONLY 5
`define FRES_BIT_CFG_SEL 6

`define FRES_KEY_FIRST 8'h55
`define FRES_KEY_SECOND 8'haa
`define FRES_BLANK_WORD 14'h3fff
`define FRES_ADDR_RST 15'h0000

`define FRES_CLK_MHZ 100
`define FRES_OP_TIME_US 2000
`define FRES_SETUP_CYC 2

`endif

// [fres_pkg.sv]
// Types shared by the flash sequencer files
// Assumes fres_regs.svh is on the include path
package fres_pkg;

    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_SETUP = 5'b00010,
        S_ERASE = 5'b00100,
        S_PROG = 5'b01000,
        S_CLEAR = 5'b10000
    } fres_state_t;

    typedef struct packed {
        logic erase;
        logic prog;
        logic [9:0] rowAddr;
        logic wordWe;
        logic [4:0] wordIdx;
        logic [13:0] wordData;
    } fres_flash_t;

endpackage : fres_pkg

// [fres_latch_bank.sv]
// Bank of program-word write latches with a blanking clear
// Assumes one writer and a combinational read port on the same clock
`include "fres_regs.svh"

module fres_latch_bank #(
    parameter int unsigned WIDTH = 14,
    parameter int unsigned DEPTH = 32,
    parameter int unsigned IDX_W = 5
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic program_write_enable,
    input wire logic [IDX_W-1:0] wrIdx,
    input wire logic [WIDTH-1:0] wrData,
    input wire logic clearAll,
    input wire logic [IDX_W-1:0] rdIdx,
    output logic [WIDTH-1:0] rdData
);
    logic [WIDTH-1:0] latch_ff [DEPTH];

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                latch_ff[i] <= WIDTH'(`FRES_BLANK_WORD);
            end
        end else if (clearAll) begin
            for (int i = 0; i < DEPTH; i++) begin
                latch_ff[i] <= WIDTH'(`FRES_BLANK_WORD);
            end
        end else if (program_write_enable) begin
            latch_ff[wrIdx] <= wrData;
        end
    end

    assign rdData = latch_ff[rdIdx];
endmodule : fres_latch_bank

// [fres_op_timer.sv]
// Down-counter timing one erase or program operation
// Assumes start is a one-cycle pulse while not busy
module fres_op_timer #(
    parameter int unsigned CYCLES = 200000,
    parameter int unsigned CNT_W = 18
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic start,
    output logic done
);
    logic [CNT_W-1:0] cnt_ff;
    logic run_ff;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_ff <= '0;
            run_ff <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                cnt_ff <= CNT_W'(CYCLES - 1);
                run_ff <= 1'b1;
            end else if (run_ff) begin
                if (cnt_ff == '0) begin
                    run_ff <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff - 1'b1;
                end
            end
        end
    end
endmodule : fres_op_timer

// [fres_seq.sv]
// Self-programming sequencer for program flash: registers, unlock and control
// Assumes an APB master on ref_clk, a flash macro on flashOut, and a core
// that honours cpuNopForce and cpuStall.
//
// Design decisions made here: the APB register port and the register offsets.
`include "fres_regs.svh"

module fres_seq #(
    parameter int unsigned OP_CYCLES = `FRES_OP_TIME_US * `FRES_CLK_MHZ,
    parameter int unsigned LATCHES = 32
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic por_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`FRES_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output logic cpuNopForce,
    output logic cpuStall,
    output fres_pkg::fres_flash_t flashOut
);
    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [`FRES_ADDR_W-1:0] a, input logic [`FRES_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    function automatic logic mapped(input logic [`FRES_ADDR_W-1:0] a);
        mapped = hit(a, `FRES_OFF_CTRL) | hit(a, `FRES_OFF_UNLOCK) | hit(a, `FRES_OFF_ADDR_LO)
            | hit(a, `FRES_OFF_ADDR_HI) | hit(a, `FRES_OFF_DATA_LO) | hit(a, `FRES_OFF_DATA_HI);
    endfunction : mapped

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic rd_ff;
    logic wr_ff;
    logic writeEn_ff;
    logic erase_ff;
    logic loadOnly_ff;
    logic cfgSel_ff;
    logic write_error_flag_ff;
    logic inFlight_ff;
    logic relSeen_ff;
    logic [14:0] addr_ff;
    logic [7:0] dataLo_ff;
    logic [5:0] dataHi_ff;
    logic keyHalf_ff;
    logic armed_ff;
    fres_pkg::fres_state_t state_ff;
    fres_pkg::fres_state_t nxt_state;
    logic [1:0] setupCnt_ff;
    logic modeLoad_ff;
    logic modeErase_ff;
    logic [5:0] progIdx_ff;
    logic [9:0] opRow_ff;
    logic cpuNopForce_ff;
    logic cpuStall_ff;
    fres_pkg::fres_flash_t flash_ff;

    logic wrAcc;
    logic ctrlWr;
    logic startOp;
    logic setupLast;
    logic timerDone;
    logic clearWr;
    logic [13:0] latchRd;

    assign wrAcc = psel & penable & pready_ff & pwrite;
    assign ctrlWr = wrAcc & hit(paddr, `FRES_OFF_CTRL);
    // Start only with the key armed and write enable in the same write
    assign startOp = ctrlWr & pwdata[`FRES_BIT_WR] & armed_ff & pwdata[`FRES_BIT_WRITE_EN]
        & (state_ff == fres_pkg::S_IDLE);
    assign setupLast = (state_ff == fres_pkg::S_SETUP) & (setupCnt_ff == 2'(`FRES_SETUP_CYC - 1));
    assign clearWr = (setupLast & modeLoad_ff) | (state_ff == fres_pkg::S_CLEAR);

    // ------------------------------------------------------------------
    // APB slave: zero-wait answer, registered read data
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= psel & ~penable;
            pslverr_ff <= psel & ~penable & ~mapped(paddr);
            if (psel & ~penable & ~pwrite) begin
                unique case (1'b1)
                    hit(paddr, `FRES_OFF_CTRL): begin
                        prdata_ff <= {25'h0, cfgSel_ff, loadOnly_ff, erase_ff, write_error_flag_ff, writeEn_ff, wr_ff, rd_ff};
                    end
                    hit(paddr, `FRES_OFF_ADDR_LO): begin
                        prdata_ff <= {24'h0, addr_ff[7:0]};
                    end
                    hit(paddr, `FRES_OFF_ADDR_HI): begin
                        prdata_ff <= {25'h0, addr_ff[14:8]};
                    end
                    hit(paddr, `FRES_OFF_DATA_LO): begin
                        prdata_ff <= {24'h0, dataLo_ff};
                    end
                    hit(paddr, `FRES_OFF_DATA_HI): begin
                        prdata_ff <= {26'h0, dataHi_ff};
                    end
                    default: begin
                        prdata_ff <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Address and data registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            addr_ff <= `FRES_ADDR_RST;
            dataLo_ff <= 8'h00;
            dataHi_ff <= 6'h00;
        end else if (wrAcc) begin
            if (hit(paddr, `FRES_OFF_ADDR_LO)) begin
                addr_ff[7:0] <= pwdata[7:0];
            end
            if (hit(paddr, `FRES_OFF_ADDR_HI)) begin
                addr_ff[14:8] <= pwdata[6:0];
            end
            if (hit(paddr, `FRES_OFF_DATA_LO)) begin
                dataLo_ff <= pwdata[7:0];
            end
            if (hit(paddr, `FRES_OFF_DATA_HI)) begin
                dataHi_ff <= pwdata[5:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Unlock detector
    // ------------------------------------------------------------------
    // Any write other than the next expected one drops the key, so a
    // stray write between the two halves or before the start disarms.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            keyHalf_ff <= 1'b0;
            armed_ff <= 1'b0;
        end else if (wrAcc) begin
            keyHalf_ff <= 1'b0;
            armed_ff <= 1'b0;
            if (hit(paddr, `FRES_OFF_UNLOCK)) begin
                if (pwdata[7:0] == `FRES_KEY_FIRST) begin
                    keyHalf_ff <= 1'b1;
                end else if (keyHalf_ff && pwdata[7:0] == `FRES_KEY_SECOND) begin
                    armed_ff <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Control bits
    // ------------------------------------------------------------------
    // Mode bits are frozen while an operation runs
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            writeEn_ff <= 1'b0;
            erase_ff <= 1'b0;
            loadOnly_ff <= 1'b0;
            cfgSel_ff <= 1'b0;
        end else if (ctrlWr && state_ff == fres_pkg::S_IDLE) begin
            writeEn_ff <= pwdata[`FRES_BIT_WRITE_EN];
            erase_ff <= pwdata[`FRES_BIT_FREE];
            loadOnly_ff <= pwdata[`FRES_BIT_LOAD_ONLY];
            cfgSel_ff <= pwdata[`FRES_BIT_CFG_SEL];
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
        end else begin
            if (startOp) begin
                wr_ff <= 1'b1;
            end else if (clearWr) begin
                wr_ff <= 1'b0;
            end
            // Reads are not served here, so the read bit self-clears
            rd_ff <= ctrlWr & pwdata[`FRES_BIT_RD] & ~rd_ff;
        end
    end

    // ------------------------------------------------------------------
    // Write error across a reset
    // ------------------------------------------------------------------
    // write_error_flag_ff survives the system reset, which clears inFlight_ff on the same edge that flags it; power-on clears both.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            relSeen_ff <= 1'b0;
        end else begin
            relSeen_ff <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge por_rst) begin
        if (por_rst) begin
            inFlight_ff <= 1'b0;
            write_error_flag_ff <= 1'b0;
        end else begin
            if (startOp && !pwdata[`FRES_BIT_LOAD_ONLY]) begin
                inFlight_ff <= 1'b1;
            end else if (state_ff == fres_pkg::S_CLEAR || !relSeen_ff) begin
                inFlight_ff <= 1'b0;
            end
            if (!relSeen_ff && inFlight_ff) begin
                write_error_flag_ff <= 1'b1;
            end else if (ctrlWr && !pwdata[`FRES_BIT_WRITE_ERR]) begin
                write_error_flag_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Operation state machine
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            fres_pkg::S_IDLE: begin
                if (startOp) begin
                    nxt_state = fres_pkg::S_SETUP;
                end
            end
            fres_pkg::S_SETUP: begin
                if (setupLast) begin
                    if (modeLoad_ff) begin
                        nxt_state = fres_pkg::S_IDLE;
                    end else if (modeErase_ff) begin
                        nxt_state = fres_pkg::S_ERASE;
                    end else begin
                        nxt_state = fres_pkg::S_PROG;
                    end
                end
            end
            fres_pkg::S_ERASE, fres_pkg::S_PROG: begin
                if (timerDone) begin
                    nxt_state = fres_pkg::S_CLEAR;
                end
            end
            fres_pkg::S_CLEAR: begin
                nxt_state = fres_pkg::S_IDLE;
            end
            default: begin
                nxt_state = fres_pkg::S_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= fres_pkg::S_IDLE;
            setupCnt_ff <= 2'h0;
            modeLoad_ff <= 1'b0;
            modeErase_ff <= 1'b0;
            opRow_ff <= 10'h000;
        end else begin
            state_ff <= nxt_state;
            if (startOp) begin
                setupCnt_ff <= 2'h0;
                modeLoad_ff <= pwdata[`FRES_BIT_LOAD_ONLY];
                modeErase_ff <= pwdata[`FRES_BIT_FREE] & ~pwdata[`FRES_BIT_LOAD_ONLY];
                opRow_ff <= addr_ff[14:5];
            end else if (state_ff == fres_pkg::S_SETUP) begin
                setupCnt_ff <= setupCnt_ff + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Latches, timer and program word stream
    // ------------------------------------------------------------------
    fres_latch_bank #(
        .WIDTH(14),
        .DEPTH(LATCHES),
        .IDX_W(5)
    ) u_latches (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .program_write_enable(startOp & ~pwdata[`FRES_BIT_FREE]),
        .wrIdx(addr_ff[4:0]),
        .wrData({dataHi_ff, dataLo_ff}),
        .clearAll(state_ff == fres_pkg::S_CLEAR),
        .rdIdx(progIdx_ff[4:0]),
        .rdData(latchRd)
    );

    fres_op_timer #(
        .CYCLES(OP_CYCLES),
        .CNT_W($clog2(OP_CYCLES + 1))
    ) u_timer (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .start(setupLast & ~modeLoad_ff),
        .done(timerDone)
    );

    // All latches go out in one burst, one word per cycle, never past the row
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            progIdx_ff <= 6'h00;
            flash_ff <= '0;
        end else begin
            flash_ff.erase <= (nxt_state == fres_pkg::S_ERASE);
            flash_ff.prog <= (nxt_state == fres_pkg::S_PROG);
            flash_ff.rowAddr <= opRow_ff;
            flash_ff.wordWe <= 1'b0;
            if (state_ff != fres_pkg::S_PROG) begin
                progIdx_ff <= 6'h00;
            end else if (progIdx_ff < 6'(LATCHES)) begin
                flash_ff.wordWe <= 1'b1;
                flash_ff.wordIdx <= progIdx_ff[4:0];
                flash_ff.wordData <= latchRd;
                progIdx_ff <= progIdx_ff + 6'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cpuNopForce_ff <= 1'b0;
            cpuStall_ff <= 1'b0;
        end else begin
            cpuNopForce_ff <= (nxt_state == fres_pkg::S_SETUP);
            cpuStall_ff <= (nxt_state == fres_pkg::S_ERASE) | (nxt_state == fres_pkg::S_PROG)
                | (nxt_state == fres_pkg::S_CLEAR);
        end
    end

    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign prdata = prdata_ff;
    assign cpuNopForce = cpuNopForce_ff;
    assign cpuStall = cpuStall_ff;
    assign flashOut = flash_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_erase_row: assert property (@(posedge ref_clk) disable iff (sys_rst)
        startOp |=> (opRow_ff == addr_ff[14:5]))
        else $error("erase row not taken from upper address bits");

    chk_two_nops: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(cpuNopForce) |-> cpuNopForce[*2] ##1 !cpuNopForce)
        else $error("forced nop window is not two cycles");

    chk_erase_stall: assert property (@(posedge ref_clk) disable iff (sys_rst)
        flashOut.erase |-> cpuStall && !cpuNopForce)
        else $error("core not stalled during erase");

    chk_resume_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $fell(cpuStall) |-> !wr_ff && state_ff == fres_pkg::S_IDLE)
        else $error("core resumed before operation finished");

    chk_no_auto_erase: assert property (@(posedge ref_clk) disable iff (sys_rst)
        flashOut.prog |-> !flashOut.erase)
        else $error("erase raised during program");

    chk_word_bound: assert property (@(posedge ref_clk) disable iff (sys_rst)
        flashOut.wordWe |-> flashOut.prog && progIdx_ff <= 6'(LATCHES))
        else $error("program word beyond row");

    chk_latch_blank: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_ff == fres_pkg::S_CLEAR |=> latchRd == `FRES_BLANK_WORD)
        else $error("latches not blank after operation");

    chk_load_only: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (startOp && pwdata[`FRES_BIT_LOAD_ONLY]) |-> ##3 (state_ff == fres_pkg::S_IDLE && !flashOut.prog && !wr_ff))
        else $error("load-only start did not return idle");

    chk_prog_start: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (startOp && !pwdata[`FRES_BIT_LOAD_ONLY] && !pwdata[`FRES_BIT_FREE]) |-> ##3 state_ff == fres_pkg::S_PROG)
        else $error("program did not start after setup");

    chk_unlock_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (ctrlWr && !armed_ff && state_ff == fres_pkg::S_IDLE) |=> state_ff == fres_pkg::S_IDLE)
        else $error("operation started without unlock");

    chk_unlock_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (psel && !penable && !pwrite && paddr == `FRES_OFF_UNLOCK) |=> prdata == 32'h0000_0000)
        else $error("unlock register read not zero");

    chk_write_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (ctrlWr && !pwdata[`FRES_BIT_WRITE_EN] && state_ff == fres_pkg::S_IDLE) |=> !wr_ff)
        else $error("write started without enable");
endmodule : fres_seq

// [fres_seq_bench.sv]
// Self-checking bench for the flash row erase and write sequencer
// Assumes zero-wait APB answers and OP_CYCLES shortened to 50 cycles
`include "fres_regs.svh"

module fres_seq_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int OPC = 50;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic por_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic pready, pslverr, cpuNopForce, cpuStall, errv;
    logic [31:0] prdata, rdv;
    fres_pkg::fres_flash_t flashOut;
    logic [13:0] seen [32];
    logic [9:0] rowSeen;
    int badCount = 0;
    int cmpCount = 0;
    int nopCnt, stallCnt, eraseCnt, weCnt, progCnt;

    always #5 ref_clk = ~ref_clk;

    fres_seq #(.OP_CYCLES(OPC), .LATCHES(32)) fres_seq_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .por_rst(por_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .cpuNopForce(cpuNopForce), .cpuStall(cpuStall), .flashOut(flashOut));

    // --------------------------------------------------------------
    // Flash-side monitor
    // --------------------------------------------------------------
    always @(posedge ref_clk) begin
        nopCnt += int'(cpuNopForce === 1'b1);
        stallCnt += int'(cpuStall === 1'b1);
        eraseCnt += int'(flashOut.erase === 1'b1);
        progCnt += int'(flashOut.prog === 1'b1);
        if (flashOut.wordWe === 1'b1 || flashOut.erase === 1'b1) begin
            rowSeen = flashOut.rowAddr;
        end
        if (flashOut.wordWe === 1'b1) begin
            seen[flashOut.wordIdx] = flashOut.wordData;
            weCnt++;
        end
    end

    // --------------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------------
    task automatic finishTest();
        if (badCount == 0 && cmpCount > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finishTest

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            badCount++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Waits for pready as long as it takes; only the watchdog ends a hang
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic setad(input logic [14:0] a, input logic [13:0] d);
        apb(1'b1, `FRES_OFF_ADDR_LO, {24'h0, a[7:0]});
        apb(1'b1, `FRES_OFF_ADDR_HI, {25'h0, a[14:8]});
        apb(1'b1, `FRES_OFF_DATA_LO, {24'h0, d[7:0]});
        apb(1'b1, `FRES_OFF_DATA_HI, {26'h0, d[13:8]});
    endtask : setad

    // Clears the monitor, unlocks, starts, waits out any stall, reads control back
    task automatic run(input logic [7:0] ctl);
        int n;
        nopCnt = 0;
        stallCnt = 0;
        eraseCnt = 0;
        weCnt = 0;
        progCnt = 0;
        for (n = 0; n < 32; n++) seen[n] = 14'h0000;
        apb(1'b1, `FRES_OFF_UNLOCK, 32'h55);
        apb(1'b1, `FRES_OFF_UNLOCK, 32'haa);
        apb(1'b1, `FRES_OFF_CTRL, {24'h0, ctl});
        repeat (4) @(posedge ref_clk);
        for (n = 0; n < 400 && cpuStall !== 1'b0; n++) @(posedge ref_clk);
        if (cpuStall !== 1'b0) begin
            badCount++;
            finishTest();
        end
        apb(1'b0, `FRES_OFF_CTRL, 32'h0);
    endtask : run

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_regs();
        apb(1'b0, `FRES_OFF_CTRL, 32'h0);
        chk(rdv, 32'h0);
        apb(1'b1, `FRES_OFF_ADDR_LO, 32'ha5);
        apb(1'b0, `FRES_OFF_ADDR_LO, 32'h0);
        chk(rdv, 32'ha5);
        apb(1'b1, `FRES_OFF_UNLOCK, 32'h55);
        apb(1'b0, `FRES_OFF_UNLOCK, 32'h0);
        chk(rdv, 32'h0);
        apb(1'b1, `FRES_OFF_CTRL, 32'h1);
        apb(1'b0, `FRES_OFF_CTRL, 32'h0);
        chk(rdv & 32'h1, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, errv}, 32'h1);
    endtask : t_regs

    task automatic t_load_and_refuse();
        setad(15'h1223, 14'h1a5c);
        run(8'h26);
        chk(nopCnt, 2);
        chk(stallCnt + weCnt, 0);
        chk(rdv & 32'h2, 32'h0);
        // Interrupted key must not load latch 4
        setad(15'h1224, 14'h2bbb);
        apb(1'b1, `FRES_OFF_UNLOCK, 32'h55);
        apb(1'b1, `FRES_OFF_ADDR_LO, 32'h24);
        apb(1'b1, `FRES_OFF_UNLOCK, 32'haa);
        nopCnt = 0;
        apb(1'b1, `FRES_OFF_CTRL, 32'h26);
        repeat (6) @(posedge ref_clk);
        chk(nopCnt, 0);
        run(8'h22);
        chk(nopCnt, 0);
    endtask : t_load_and_refuse

    task automatic t_prog(input logic [14:0] a, input logic [13:0] d, input logic [4:0] ld, input logic [13:0] ldv);
        setad(a, d);
        run(8'h06);
        chk(weCnt, 32);
        chk(rowSeen, {22'h0, a[14:5]});
        for (int i = 0; i < 32; i++) begin
            chk(seen[i], (i == a[4:0]) ? d : (i == ld) ? ldv : `FRES_BLANK_WORD);
        end
        chk(eraseCnt, 0);
        chk(int'(progCnt >= OPC), 1);
        chk(int'(stallCnt >= OPC) + nopCnt, 3);
        chk(rdv & 32'h2, 32'h0);
    endtask : t_prog

    task automatic t_erase();
        setad(15'h2b40, 14'h0777);
        run(8'h26);
        setad(15'h2b4d, 14'h0000);
        run(8'h16);
        chk(rowSeen, 10'h15a);
        chk(progCnt, 0);
        chk(int'(eraseCnt >= OPC) + weCnt, 1);
        chk(int'(stallCnt >= OPC) + nopCnt, 3);
        t_prog(15'h2b5f, 14'h1111, 5'h1f, 14'h1111);
    endtask : t_erase

    task automatic t_write_error_flag();
        apb(1'b1, `FRES_OFF_UNLOCK, 32'h55);
        apb(1'b1, `FRES_OFF_UNLOCK, 32'haa);
        apb(1'b1, `FRES_OFF_CTRL, 32'h16);
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        apb(1'b0, `FRES_OFF_CTRL, 32'h0);
        chk(rdv & 32'h8, 32'h8);
        apb(1'b1, `FRES_OFF_CTRL, 32'h0);
        apb(1'b0, `FRES_OFF_CTRL, 32'h0);
        chk(rdv & 32'h8, 32'h0);
    endtask : t_write_error_flag

    // --------------------------------------------------------------
    // Main sequence and watchdog
    // --------------------------------------------------------------
    initial begin
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        por_rst <= 1'b0;
        t_regs();
        t_load_and_refuse();
        t_prog(15'h1225, 14'h0123, 5'h03, 14'h1a5c);
        t_erase();
        t_write_error_flag();
        finishTest();
    end

    // Whole run needs a few hundred cycles; ten thousand means a hang
    initial begin
        #100000;
        badCount++;
        finishTest();
    end
endmodule : fres_seq_bench
